// ===== rtl/dual_timer_counter.sv
// Two 8-bit-pair timer/counters with external interrupt edge flags.
// Assumes an AHB-Lite master, one clock, pins asynchronous to it.
//
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "timer_defs.svh"
module dual_timer_counter (
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        ext_irq0_pin,
   input  wire logic        ext_irq1_pin,
   input  wire logic        timer0_count_pin,
   input  wire logic        timer1_count_pin,
   input  wire logic        timer0_vector_ack,
   input  wire logic        timer1_vector_ack,
   input  wire logic        ext_irq0_vector_ack,
   input  wire logic        ext_irq1_vector_ack,
   output logic             timer1_overflow_pulse,
   output logic             irq
);
   logic [3:0]  sync1;
   logic [3:0]  sync2;
   logic [3:0]  sync3;
   logic [3:0]  filt;
   logic [1:0]  pin_prev;
   logic [1:0]  cnt_samp;
   logic [3:0]  prescale;
   logic        tick;
   logic        d_we;
   logic        d_rd;
   logic [3:0]  d_idx;
   logic        tf0;
   logic        tf1;
   logic        run0;
   logic        run1;
   logic        ie0;
   logic        ie1;
   logic        it0;
   logic        it1;
   logic [7:0]  mode_cfg;
   logic [7:0]  t0_lo;
   logic [7:0]  t0_hi;
   logic [7:0]  t1_lo;
   logic [7:0]  t1_hi;
   logic [3:0]  status;
   logic [3:0]  mask;
   logic [1:0]  m0;
   logic [1:0]  m1;
   logic [16:0] st0;
   logic [16:0] st1;
   logic        inc0;
   logic        inc1;
   logic        inc_split;
   logic        ovf0;
   logic        ovf1;
   logic        ovf_split;
   logic        set_tf1;
   logic [1:0]  fall;
   logic        set_ie0;
   logic        set_ie1;
   logic [7:0]  ctl_word;

   // One count step: {overflow, high, low}
   function automatic logic [16:0] step(input logic [1:0] mode,
                                        input logic [7:0] lo,
                                        input logic [7:0] hi);
      logic [13:0] c13;
      logic [16:0] c16;
      logic [8:0]  c8;
      c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      c16 = {1'b0, hi, lo} + 17'h0_0001;
      c8  = {1'b0, lo} + 9'h001;
      case (mode)
         // 13-bit count, low five bits of the low byte as prescaler
         // thirteen bit count
         timer_pkg::MODE_13BIT:  step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
         timer_pkg::MODE_16BIT:  step = c16;
         timer_pkg::MODE_RELOAD: step = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
         default:                step = {1'b0, hi, lo};
      endcase
   endfunction

   // Next value of a flag that hardware sets and others clear
   function automatic logic flag_next(input logic cur, input logic set,
                                      input logic clr, input logic wr,
                                      input logic wdat);
      if (set) begin
         flag_next = 1'b1;
      end else if (clr) begin
         flag_next = 1'b0;
      end else if (wr) begin
         flag_next = wdat;
      end else begin
         flag_next = cur;
      end
   endfunction

   function automatic logic wsel(input logic [3:0] k);
      wsel = d_we && (d_idx == k);
   endfunction

   // Pin synchronisers with agreement filter
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sync1 <= `RST_PINS;
         sync2 <= `RST_PINS;
         sync3 <= `RST_PINS;
         filt  <= `RST_PINS;
      end else begin
         sync1 <= {timer1_count_pin, timer0_count_pin, ext_irq1_pin, ext_irq0_pin};
         sync2 <= sync1;
         sync3 <= sync2;
         filt  <= (sync2 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         prescale <= 4'h0;
      end else if (prescale == `MCYCLE_LAST) begin
         prescale <= 4'h0;
      end else begin
         prescale <= prescale + 4'h1;
      end
   end
   assign tick = (prescale == `MCYCLE_LAST);

   // Count pin samples once per machine cycle, interrupt pins every clock
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cnt_samp <= 2'b11;
         pin_prev <= 2'b11;
      end else begin
         pin_prev <= filt[1:0];
         if (tick) begin
            cnt_samp <= filt[3:2];
         end
      end
   end
   assign fall = pin_prev & ~filt[1:0];

   // AHB-Lite address phase capture
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         d_we  <= 1'b0;
         d_rd  <= 1'b0;
         d_idx <= 4'h0;
      end else if (hready) begin
         d_we  <= hsel && htrans[1] && hwrite;
         d_rd  <= hsel && htrans[1] && !hwrite;
         d_idx <= (haddr[31:6] == 26'h000_0000) ? haddr[5:2] : 4'hF;
      end
   end
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   assign ctl_word = {tf1, run1, tf0, run0, ie1, it1, ie0, it0};

   // read path, unmapped words read zero
   always_comb begin
      hrdata = 32'h0000_0000;
      if (d_rd) begin
         case (d_idx)
            `IDX_CONTROL: hrdata[7:0] = ctl_word;
            `IDX_MODE:    hrdata[7:0] = mode_cfg;
            `IDX_T0_LOW:  hrdata[7:0] = t0_lo;
            `IDX_T0_HIGH: hrdata[7:0] = t0_hi;
            `IDX_T1_LOW:  hrdata[7:0] = t1_lo;
            `IDX_T1_HIGH: hrdata[7:0] = t1_hi;
            `IDX_STATUS:  hrdata[3:0] = status;
            `IDX_MASK:    hrdata[3:0] = mask;
            default:      hrdata = 32'h0000_0000;
         endcase
      end
   end

   assign m0 = mode_cfg[`MODE0_MSB:`MODE0_LSB];
   assign m1 = mode_cfg[`MODE1_MSB:`MODE1_LSB];

   always_comb begin
      st0 = step(m0, t0_lo, t0_hi);
      st1 = step(m1, t1_lo, t1_hi);
      inc0 = run0 && (!mode_cfg[`BIT_GATE0] || filt[0]) &&
             (mode_cfg[`BIT_CT0] ? (tick && cnt_samp[0] && !filt[2]) : tick);
      inc1 = run1 && (!mode_cfg[`BIT_GATE1] || filt[1]) &&
             (m1 != timer_pkg::MODE_SPLIT) &&
             (mode_cfg[`BIT_CT1] ? (tick && cnt_samp[1] && !filt[3]) : tick);
      // split high byte on timer 1 run
      inc_split = (m0 == timer_pkg::MODE_SPLIT) && run1 && tick;
      ovf0 = inc0 && ((m0 == timer_pkg::MODE_SPLIT) ? (t0_lo == 8'hFF) : st0[16]);
      ovf1 = inc1 && st1[16];
      ovf_split = inc_split && (t0_hi == 8'hFF);
      // split owns the timer 1 flag
      set_tf1 = (m0 == timer_pkg::MODE_SPLIT) ? ovf_split : ovf1;
      set_ie0 = it0 ? fall[0] : !filt[0];
      set_ie1 = it1 ? fall[1] : !filt[1];
   end

   // Timer 0 count bytes
   // count bytes change only by count or write
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         t0_lo <= `RST_BYTE;
         t0_hi <= `RST_BYTE;
      end else begin
         if (inc0) begin
            if (m0 == timer_pkg::MODE_SPLIT) begin
               t0_lo <= t0_lo + 8'h01;
            end else begin
               t0_lo <= st0[7:0];
               t0_hi <= st0[15:8];
            end
         end
         if (inc_split) begin
            t0_hi <= t0_hi + 8'h01;
         end
         if (wsel(`IDX_T0_LOW)) begin
            t0_lo <= hwdata[7:0];
         end
         if (wsel(`IDX_T0_HIGH)) begin
            t0_hi <= hwdata[7:0];
         end
      end
   end

   // Timer 1 count bytes
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         t1_lo <= `RST_BYTE;
         t1_hi <= `RST_BYTE;
      end else begin
         if (inc1) begin
            t1_lo <= st1[7:0];
            t1_hi <= st1[15:8];
         end
         if (wsel(`IDX_T1_LOW)) begin
            t1_lo <= hwdata[7:0];
         end
         if (wsel(`IDX_T1_HIGH)) begin
            t1_hi <= hwdata[7:0];
         end
      end
   end

   // Overflow for a baud generator, free of the flag
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         timer1_overflow_pulse <= 1'b0;
      end else begin
         timer1_overflow_pulse <= ovf1;
      end
   end

   // Control bits and mode register
   // run bits by software
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         run0     <= 1'b0;
         run1     <= 1'b0;
         it0      <= 1'b0;
         it1      <= 1'b0;
         mode_cfg <= `RST_BYTE;
      end else begin
         if (wsel(`IDX_CONTROL)) begin
            run0 <= hwdata[`BIT_TR0];
            run1 <= hwdata[`BIT_TR1];
            it0  <= hwdata[`BIT_IT0];
            it1  <= hwdata[`BIT_IT1];
         end
         if (wsel(`IDX_MODE)) begin
            mode_cfg <= hwdata[7:0];
         end
      end
   end

   // overflow flags, set wins over vector clear
   // edge flags, set wins over service clear
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         tf0 <= 1'b0;
         tf1 <= 1'b0;
         ie0 <= 1'b0;
         ie1 <= 1'b0;
      end else begin
         tf0 <= flag_next(tf0, ovf0, timer0_vector_ack,
                          wsel(`IDX_CONTROL), hwdata[`BIT_TF0]);
         tf1 <= flag_next(tf1, set_tf1, timer1_vector_ack,
                          wsel(`IDX_CONTROL), hwdata[`BIT_TF1]);
         ie0 <= flag_next(ie0, set_ie0, ext_irq0_vector_ack,
                          wsel(`IDX_CONTROL), hwdata[`BIT_IE0]);
         ie1 <= flag_next(ie1, set_ie1, ext_irq1_vector_ack,
                          wsel(`IDX_CONTROL), hwdata[`BIT_IE1]);
      end
   end

   // Sticky event status, write one to clear, and mask
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         status <= 4'h0;
         mask   <= 4'h0;
      end else begin
         status <= (status & ~(wsel(`IDX_STATUS) ? hwdata[3:0] : 4'h0)) |
                   {fall[1], fall[0], set_tf1, ovf0};
         if (wsel(`IDX_MASK)) begin
            mask <= hwdata[3:0];
         end
      end
   end
   assign irq = |(status & mask);

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   sequence ext0_fall_s;
      filt[0] ##1 !filt[0];
   endsequence
   sequence t0_reload_s;
      inc0 && (m0 == timer_pkg::MODE_RELOAD) && (t0_lo == 8'hFF) && !d_we;
   endsequence

   tick_period_a: assert property (tick |-> ##12 tick)
      else $error("machine cycle is not twelve clocks");
   tick_gap_a: assert property (tick |=> !tick ##1 !tick)
      else $error("machine cycle ticks too close");
   ovf_flag_a: assert property (ovf0 |=> tf0)
      else $error("timer 0 overflow did not set flag");
   vector_clear_a: assert property ((timer0_vector_ack && !ovf0) |=> !tf0)
      else $error("vector did not clear timer 0 flag");
   reload_byte_a: assert property (t0_reload_s |=>
      (t0_lo == $past(t0_hi)) && $stable(t0_hi) && tf0)
      else $error("mode 2 reload wrong");
   t1_hold_a: assert property ((m1 == timer_pkg::MODE_SPLIT && !d_we) |=>
      $stable(t1_lo) && $stable(t1_hi))
      else $error("timer 1 moved in mode 3");
   run_off_a: assert property ((!run0 && !d_we && m0 != timer_pkg::MODE_SPLIT) |=>
      $stable(t0_lo) && $stable(t0_hi))
      else $error("timer 0 counted while stopped");
   split_flag_a: assert property (ovf_split |=> tf1)
      else $error("split high byte did not set timer 1 flag");
   split_quiet_a: assert property ((m0 == timer_pkg::MODE_SPLIT && ovf1 && !ovf_split &&
      !wsel(`IDX_CONTROL) && !tf1) |=> !tf1)
      else $error("timer 1 raised flag during split");
   gate_block_a: assert property ((mode_cfg[`BIT_GATE0] && !filt[0]) |-> !inc0)
      else $error("gated timer 0 counted");
   step16_a: assert property ((inc0 && m0 == timer_pkg::MODE_16BIT && !d_we) |=>
      {t0_hi, t0_lo} == $past({t0_hi, t0_lo}) + 16'h0001)
      else $error("mode 1 step wrong");
   edge_flag_a: assert property ((ext0_fall_s ##0 it0) |=> ie0)
      else $error("falling edge did not set flag");
endmodule

// ===== rtl/timer_defs.svh
// Offsets, bit positions, reset values and timing for the dual timer.
// Assumes an AHB-Lite slave with word-aligned registers.
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH
// Word indices (byte address = 4 * index)
`define IDX_CONTROL   4'h0
`define IDX_MODE      4'h1
`define IDX_T0_LOW    4'h2
`define IDX_T0_HIGH   4'h3
`define IDX_T1_LOW    4'h4
`define IDX_T1_HIGH   4'h5
`define IDX_STATUS    4'h6
`define IDX_MASK      4'h7
// Control/flag register bits
`define BIT_TF1       7
`define BIT_TR1       6
`define BIT_TF0       5
`define BIT_TR0       4
`define BIT_IE1       3
`define BIT_IT1       2
`define BIT_IE0       1
`define BIT_IT0       0
// Mode register fields
`define BIT_GATE1     7
`define BIT_CT1       6
`define BIT_GATE0     3
`define BIT_CT0       2
`define MODE1_MSB     5
`define MODE1_LSB     4
`define MODE0_MSB     1
`define MODE0_LSB     0
// Reset values
`define RST_BYTE      8'h00
`define RST_PINS      4'hF
// Oscillator clocks per machine cycle
`define MCYCLE_CLOCKS 12
`define MCYCLE_LAST   4'hB
`endif

// ===== rtl/timer_pkg.sv
// Types shared by the dual timer.
// Assumes timer_defs.svh for numeric constants.
package timer_pkg;
   typedef enum logic [1:0] {
      MODE_13BIT  = 2'b00,
      MODE_16BIT  = 2'b01,
      MODE_RELOAD = 2'b10,
      MODE_SPLIT  = 2'b11
   } timer_mode_t;
endpackage

// ===== bench/dual_timer_counter_tb.sv
// Self-checking bench for the dual timer over AHB-Lite.
// Assumes one slave, so hready is fed back from hreadyout.
`timescale 1ns/1ps
`include "timer_defs.svh"
module dual_timer_counter_tb;
   logic        clock, reset, hsel, hwrite, hreadyout, hresp, irq, ovf_pulse;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        irq0_pin, irq1_pin, cnt0_pin, cnt1_pin;
   logic        t0_ack, t1_ack, e0_ack, e1_ack;
   int          fails, check_count;

   dual_timer_counter DUT (
      .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .ext_irq0_pin(irq0_pin), .ext_irq1_pin(irq1_pin),
      .timer0_count_pin(cnt0_pin), .timer1_count_pin(cnt1_pin),
      .timer0_vector_ack(t0_ack), .timer1_vector_ack(t1_ack),
      .ext_irq0_vector_ack(e0_ack), .ext_irq1_vector_ack(e1_ack),
      .timer1_overflow_pulse(ovf_pulse), .irq(irq));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task give_verdict;
      $display("Comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task step_ready;
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         fails++;
         give_verdict;
      end
   endtask

   task addr_phase(input logic [3:0] idx, input logic wr);
      @(posedge clock);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {26'h000_0000, idx, 2'b00};
      hwrite <= wr;
      step_ready;
      htrans <= 2'b00;
   endtask

   task wr(input logic [3:0] idx, input logic [7:0] d);
      addr_phase(idx, 1'b1);
      hwdata <= {24'h00_0000, d};
      step_ready;
   endtask

   task rd(input logic [3:0] idx, output logic [31:0] v);
      addr_phase(idx, 1'b0);
      step_ready;
      v = hrdata;
   endtask

   task chk(input logic [3:0] idx, input logic [7:0] exp);
      logic [31:0] v;
      rd(idx, v);
      check(v, {24'h00_0000, exp});
   endtask

   task wait_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 200) begin
         @(posedge clock);
         n++;
      end
      if (irq !== 1'b1) begin
         fails++;
         give_verdict;
      end
   endtask

   task pulse_ack(input logic ext);
      @(posedge clock);
      if (ext) begin
         e0_ack <= 1'b1;
      end else begin
         t0_ack <= 1'b1;
      end
      @(posedge clock);
      t0_ack <= 1'b0;
      e0_ack <= 1'b0;
   endtask

   task setup(input logic [7:0] mode, input logic [7:0] mask);
      wr(`IDX_CONTROL, 8'h00);
      wr(`IDX_STATUS, 8'h0F);
      wr(`IDX_MODE, mode);
      wr(`IDX_MASK, mask);
   endtask

   task t_reset_values;
      for (int i = 0; i < 9; i++) begin
         chk(4'(i), 8'h00);
      end
   endtask

   task t_mode1_overflow;
      logic [31:0] a, b;
      setup(8'h01, 8'h01);
      wr(`IDX_T0_LOW, 8'hFE);
      wr(`IDX_T0_HIGH, 8'hFF);
      wr(`IDX_CONTROL, 8'h10);
      wait_irq;
      chk(`IDX_CONTROL, 8'h30);
      chk(`IDX_T0_HIGH, 8'h00);
      chk(`IDX_T0_LOW, 8'h00);
      pulse_ack(1'b0);
      chk(`IDX_CONTROL, 8'h10);
      wr(`IDX_STATUS, 8'h01);
      @(posedge clock);
      check(irq, 1'b0);
      wr(`IDX_CONTROL, 8'h00);
      rd(`IDX_T0_LOW, a);
      repeat (30) @(posedge clock);
      rd(`IDX_T0_LOW, b);
      check(b, a);
      wr(`IDX_T0_HIGH, 8'h66);
      wr(`IDX_CONTROL, 8'h10);
      chk(`IDX_T0_HIGH, 8'h66);
   endtask

   task t_mode0_prescale;
      logic [31:0] v;
      setup(8'h00, 8'h01);
      wr(`IDX_T0_HIGH, 8'hFF);
      wr(`IDX_T0_LOW, 8'h1F);
      wr(`IDX_CONTROL, 8'h10);
      wait_irq;
      chk(`IDX_T0_HIGH, 8'h00);
      rd(`IDX_T0_LOW, v);
      check(v & 32'h0000_001F, 32'h0000_0000);
   endtask

   task t_mode2_reload;
      setup(8'h22, 8'h02);
      wr(`IDX_T1_HIGH, 8'hF0);
      wr(`IDX_T1_LOW, 8'hFF);
      wr(`IDX_T0_HIGH, 8'hA5);
      wr(`IDX_T0_LOW, 8'hFF);
      wr(`IDX_CONTROL, 8'h50);
      wait_irq;
      chk(`IDX_T1_LOW, 8'hF0);
      chk(`IDX_T1_HIGH, 8'hF0);
      chk(`IDX_T0_LOW, 8'hA5);
      chk(`IDX_CONTROL, 8'hF0);
   endtask

   task t_gate;
      logic [31:0] v;
      setup(8'h09, 8'h00);
      irq0_pin <= 1'b0;
      wr(`IDX_T0_LOW, 8'h00);
      wr(`IDX_CONTROL, 8'h10);
      repeat (50) @(posedge clock);
      chk(`IDX_T0_LOW, 8'h00);
      irq0_pin <= 1'b1;
      repeat (50) @(posedge clock);
      rd(`IDX_T0_LOW, v);
      check(v != 32'h0000_0000, 1'b1);
   endtask

   task t_counter;
      setup(8'h05, 8'h00);
      wr(`IDX_T0_LOW, 8'h00);
      wr(`IDX_CONTROL, 8'h10);
      repeat (3) begin
         cnt0_pin <= 1'b0;
         repeat (36) @(posedge clock);
         cnt0_pin <= 1'b1;
         repeat (36) @(posedge clock);
      end
      chk(`IDX_T0_LOW, 8'h03);
   endtask

   task t_ext_edge;
      setup(8'h00, 8'h04);
      wr(`IDX_CONTROL, 8'h01);
      irq0_pin <= 1'b0;
      wait_irq;
      irq0_pin <= 1'b1;
      chk(`IDX_CONTROL, 8'h03);
      pulse_ack(1'b1);
      chk(`IDX_CONTROL, 8'h01);
   endtask

   task t_split;
      setup(8'h33, 8'h02);
      wr(`IDX_T1_LOW, 8'h10);
      wr(`IDX_T0_HIGH, 8'hFF);
      wr(`IDX_CONTROL, 8'h40);
      wait_irq;
      chk(`IDX_T0_HIGH, 8'h00);
      chk(`IDX_T1_LOW, 8'h10);
      chk(`IDX_CONTROL, 8'hC0);
   endtask

   task t_split_baud;
      int n;
      setup(8'h23, 8'h02);
      wr(`IDX_T0_HIGH, 8'h00);
      wr(`IDX_T1_HIGH, 8'hFE);
      wr(`IDX_T1_LOW, 8'hFE);
      wr(`IDX_CONTROL, 8'h40);
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (ovf_pulse !== 1'b1 && n < 60);
      check(ovf_pulse, 1'b1);
      chk(`IDX_T1_LOW, 8'hFE);
      chk(`IDX_CONTROL, 8'h40);
      chk(`IDX_STATUS, 8'h00);
   endtask

   initial begin
      fails = 0;
      check_count = 0;
      reset = 1'b1;
      {hsel, hwrite, t0_ack, t1_ack, e0_ack, e1_ack} = 6'h00;
      {irq0_pin, irq1_pin, cnt0_pin, cnt1_pin} = 4'hF;
      htrans = 2'b00;
      hsize = 3'b010;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      t_reset_values;
      t_mode1_overflow;
      t_mode0_prescale;
      t_mode2_reload;
      t_gate;
      t_counter;
      t_ext_edge;
      t_split;
      t_split_baud;
      give_verdict;
   end
endmodule
